// *** common/clock_ctrl_defines.svh ***
// Offsets, field positions, reset values and timing counts of the clock control block
// Assumes a 125 MHz system clock and a 24-bit phase accumulator per clock generator
`ifndef CLOCK_CTRL_DEFINES_SVH
`define CLOCK_CTRL_DEFINES_SVH

// ==========================================================
// Timing
`define MCLK_MHZ         125
`define SAMPLE_TIME_US   2000
`define SAMPLE_CYCLES    (`SAMPLE_TIME_US * `MCLK_MHZ)
`define RESTART_MAX_US   3000
`define RESTART_CYCLES   (`RESTART_MAX_US * `MCLK_MHZ)

// ==========================================================
// Strap pin positions
`define STRAP_SEL0       0
`define STRAP_SEL1       1
`define STRAP_SEL2       2
`define STRAP_MODE       3
`define STRAP_SWING      4

// ==========================================================
// Clock generator slots
`define NCO_PROC         0
`define NCO_BUS          1
`define NCO_REF          2
`define NCO_USB          3
`define NCO_SIO          4

// ==========================================================
// Registers
`define REG_CTRL_ADDR    4'h0
`define REG_STAT_ADDR    4'h4
`define REG_CTRL_RESET   8'h00
`define CTRL_DIS_PROC    0
`define CTRL_DIS_MEM     1
`define CTRL_DIS_BUS     2
`define CTRL_DIS_REF     3
`define CTRL_DIS_FIXED   4

// ==========================================================
// Phase increments, frequency * 2^24 / 125 MHz
`define INC_50_0         24'h666666
`define INC_25_0         24'h333333
`define INC_75_0         24'h999999
`define INC_32_0         24'h418937
`define INC_83_3         24'haa9951
`define INC_41_65        24'h554ca8
`define INC_68_5         24'h8c49ba
`define INC_34_25        24'h4624dd
`define INC_55_0         24'h70a3d7
`define INC_27_5         24'h3851ec
`define INC_37_5         24'h4ccccd
`define INC_60_0         24'h7ae148
`define INC_30_0         24'h3d70a4
`define INC_66_8         24'h88ce70
`define INC_33_4         24'h446738
`define INC_14_318       24'h1d52c1
`define INC_48_0         24'h624dd3
`define INC_24_0         24'h3126e9

`endif

// *** common/clock_ctrl_pkg.sv ***
// Types shared by the clock control block
// Assumes nothing beyond the defines header
package clock_ctrl_pkg;

  // ==========================================================
  // Power-up sequence
  typedef enum logic [1:0] {
    ST_WAIT_SUPPLY,
    ST_SAMPLE,
    ST_RUN
  } state_t;

  typedef logic [23:0] phase_inc_t;

endpackage

// *** common/nco_if.sv ***
// Control and output of one phase-accumulator clock generator
// Assumes the controller and generator share one clock
`timescale 1ns/100ps
interface nco_if #(parameter int W = 24);
  logic         run;
  logic [W-1:0] inc;
  logic         clk;
  logic         wrap;
  logic         idle;

  modport ctrl (output run, output inc, input clk, input wrap, input idle);
  modport gen  (input run, input inc, output clk, output wrap, output idle);
endinterface

// *** hw/clk_nco.sv ***
// Phase accumulator clock generator that stops low only after a complete cycle
// Assumes run and inc come from logic on the same clock
`timescale 1ns/100ps
module clk_nco #(
  parameter int W = 24
) (
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  nco_if.gen        nco
);

  logic [W-1:0] phase_reg;
  logic [W:0]   sum;

  assign sum = {1'b0, phase_reg} + {1'b0, nco.inc};

  // ==========================================================
  // Accumulator
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      phase_reg <= '0;
    end else if (nco.run) begin
      phase_reg <= sum[W-1:0];
    end else if (phase_reg == '0) begin
      phase_reg <= '0;
    end else if (sum[W]) begin
      phase_reg <= '0;
    end else begin
      phase_reg <= sum[W-1:0];
    end
  end

  assign nco.clk  = phase_reg[W-1];
  assign nco.wrap = sum[W] & (nco.run | (phase_reg != '0));
  assign nco.idle = !nco.run && (phase_reg == '0);

  // ==========================================================
  // Checks
  a_nco_parked_low: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (!nco.run && phase_reg == '0) |=> (nco.clk == 1'b0 && phase_reg == '0))
    else $error("stopped generator left its low park");
  a_nco_wrap_low: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (nco.wrap && !nco.run) |=> (!nco.clk && phase_reg == '0))
    else $error("stopping generator not parked low at cycle end");

endmodule

// *** hw/clock_ctrl.sv ***
// Strap latch, pin role selection and clock gating of a motherboard clock synthesizer
// Assumes pins arrive unsynchronised and reset comes only from power-on
`timescale 1ns/100ps
`include "clock_ctrl_defines.svh"
module clock_ctrl #(
  parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES,
  parameter int ACC_W         = 24
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        supply_ok_in,
  input  wire logic [4:0]  strap_pins_in,
  output logic      [4:0]  strap_pins_out,
  output logic      [4:0]  strap_pins_oe_out,
  input  wire logic        bus_clk_5_in,
  output logic             bus_clk_5_out,
  output logic             bus_clk_5_oe_out,
  input  wire logic        ref_clk_1_in,
  output logic             ref_clk_1_out,
  output logic             ref_clk_1_oe_out,
  output logic      [3:0]  proc_clk_out,
  output logic      [11:0] mem_clk_out,
  output logic      [3:0]  bus_clk_out,
  output logic             irq_ctrl_clk_out,
  output logic             proc_swing_sel_out,
  output logic      [2:0]  freq_sel_out,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out
);

  localparam int NCO_N = 5;

  // ==========================================================
  // Input synchronisers
  logic [7:0] raw_in;
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic [7:0] sync3_reg;
  logic [7:0] filt_reg;

  assign raw_in = {supply_ok_in, ref_clk_1_in, bus_clk_5_in, strap_pins_in};

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      sync3_reg <= 8'h00;
      filt_reg  <= 8'h00;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg  <= (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg ^ sync3_reg));
    end
  end

  // ==========================================================
  // Power-up strap sequence
  clock_ctrl_pkg::state_t state_reg;
  logic [31:0]            timer_reg;
  logic [4:0]             strap_reg;
  logic                   latched_reg;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_reg <= clock_ctrl_pkg::ST_WAIT_SUPPLY;
      timer_reg <= 32'h0000_0000;
    end else begin
      case (state_reg)
        clock_ctrl_pkg::ST_WAIT_SUPPLY: begin
          timer_reg <= 32'h0000_0000;
          if (filt_reg[7]) begin
            state_reg <= clock_ctrl_pkg::ST_SAMPLE;
          end
        end
        clock_ctrl_pkg::ST_SAMPLE: begin
          if (timer_reg == 32'(SAMPLE_CYCLES - 1)) begin
            state_reg <= clock_ctrl_pkg::ST_RUN;
          end else begin
            timer_reg <= timer_reg + 32'h0000_0001;
          end
        end
        clock_ctrl_pkg::ST_RUN: begin
          state_reg <= clock_ctrl_pkg::ST_RUN;
        end
        default: begin
          state_reg <= clock_ctrl_pkg::ST_WAIT_SUPPLY;
        end
      endcase
    end
  end

  // Straps are caught once and only power-on reset clears them
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      strap_reg   <= 5'h00;
      latched_reg <= 1'b0;
    end else if (state_reg == clock_ctrl_pkg::ST_SAMPLE && timer_reg == 32'(SAMPLE_CYCLES - 1)) begin
      strap_reg   <= filt_reg[4:0];
      latched_reg <= 1'b1;
    end
  end

  logic [2:0] freq_sel;
  logic       pin_mode;
  logic       standby_act;
  logic       halt_act;

  assign freq_sel    = strap_reg[`STRAP_SEL2:`STRAP_SEL0];
  assign pin_mode    = strap_reg[`STRAP_MODE];
  assign standby_act = latched_reg && !pin_mode && !filt_reg[5];
  assign halt_act    = latched_reg && !pin_mode && !filt_reg[6];

  // ==========================================================
  // Frequency table
  clock_ctrl_pkg::phase_inc_t proc_inc;
  clock_ctrl_pkg::phase_inc_t bus_inc;

  always_comb begin
    case (freq_sel)
      3'h0: begin
        proc_inc = `INC_50_0;
        bus_inc  = `INC_25_0;
      end
      3'h1: begin
        proc_inc = `INC_75_0;
        bus_inc  = `INC_32_0;
      end
      3'h2: begin
        proc_inc = `INC_83_3;
        bus_inc  = `INC_41_65;
      end
      3'h3: begin
        proc_inc = `INC_68_5;
        bus_inc  = `INC_34_25;
      end
      3'h4: begin
        proc_inc = `INC_55_0;
        bus_inc  = `INC_27_5;
      end
      3'h5: begin
        proc_inc = `INC_75_0;
        bus_inc  = `INC_37_5;
      end
      3'h6: begin
        proc_inc = `INC_60_0;
        bus_inc  = `INC_30_0;
      end
      default: begin
        proc_inc = `INC_66_8;
        bus_inc  = `INC_33_4;
      end
    endcase
  end

  // ==========================================================
  // Clock generators
  logic [ACC_W-1:0] inc_tab [NCO_N];
  logic [NCO_N-1:0] run_vec;
  logic [NCO_N-1:0] nco_clk;
  logic [NCO_N-1:0] nco_wrap;
  logic [NCO_N-1:0] nco_idle;
  logic             core_run;

  assign core_run = latched_reg && !standby_act;

  assign inc_tab[`NCO_PROC] = proc_inc;
  assign inc_tab[`NCO_BUS]  = bus_inc;
  assign inc_tab[`NCO_REF]  = `INC_14_318;
  assign inc_tab[`NCO_USB]  = `INC_48_0;
  assign inc_tab[`NCO_SIO]  = `INC_24_0;
  assign run_vec = {latched_reg, latched_reg, latched_reg, core_run, core_run};

  nco_if #(.W(ACC_W)) nco_bus [NCO_N] ();

  genvar gi;
  generate
    for (gi = 0; gi < NCO_N; gi++) begin : g_nco
      assign nco_bus[gi].run  = run_vec[gi];
      assign nco_bus[gi].inc  = inc_tab[gi];
      assign nco_clk[gi]      = nco_bus[gi].clk;
      assign nco_wrap[gi]     = nco_bus[gi].wrap;
      assign nco_idle[gi]     = nco_bus[gi].idle;
      clk_nco #(.W(ACC_W)) u_nco (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .nco      (nco_bus[gi].gen)
      );
    end
  endgenerate

  // Processor gate moves only on a cycle boundary so cycles stay whole
  logic proc_gate_reg;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      proc_gate_reg <= 1'b0;
    end else if (nco_wrap[`NCO_PROC] || nco_idle[`NCO_PROC]) begin
      proc_gate_reg <= !halt_act;
    end
  end

  // ==========================================================
  // Registers
  logic [7:0] ctrl_reg;
  logic [7:0] status;

  assign status = {halt_act, standby_act, latched_reg, strap_reg[`STRAP_SWING], pin_mode, freq_sel};

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ctrl_reg <= `REG_CTRL_RESET;
    end else if (reg_wr_in && reg_addr_in == `REG_CTRL_ADDR) begin
      ctrl_reg <= reg_wdata_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in && reg_addr_in == `REG_CTRL_ADDR) begin
      reg_rdata_out <= ctrl_reg;
    end else if (reg_rd_in && reg_addr_in == `REG_STAT_ADDR) begin
      reg_rdata_out <= status;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // ==========================================================
  // Output flops
  logic proc_on;
  logic mem_on;
  logic bus_on;
  logic ref_on;
  logic usb_on;
  logic sio_on;

  assign mem_on  = nco_clk[`NCO_PROC] && !ctrl_reg[`CTRL_DIS_MEM];
  assign proc_on = nco_clk[`NCO_PROC] && proc_gate_reg && !ctrl_reg[`CTRL_DIS_PROC];
  assign bus_on  = nco_clk[`NCO_BUS] && !ctrl_reg[`CTRL_DIS_BUS];
  assign ref_on  = nco_clk[`NCO_REF] && !standby_act && !ctrl_reg[`CTRL_DIS_REF];
  assign usb_on  = nco_clk[`NCO_USB] && !standby_act && !ctrl_reg[`CTRL_DIS_FIXED];
  assign sio_on  = nco_clk[`NCO_SIO] && !standby_act && !ctrl_reg[`CTRL_DIS_FIXED];

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      proc_clk_out     <= 4'h0;
      mem_clk_out      <= 12'h000;
      bus_clk_out      <= 4'h0;
      irq_ctrl_clk_out <= 1'b0;
    end else begin
      proc_clk_out     <= {4{proc_on}};
      mem_clk_out      <= {12{mem_on}};
      bus_clk_out      <= {4{bus_on}};
      irq_ctrl_clk_out <= ref_on;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      strap_pins_out    <= 5'h00;
      strap_pins_oe_out <= 5'h00;
      bus_clk_5_out     <= 1'b0;
      bus_clk_5_oe_out  <= 1'b0;
      ref_clk_1_out     <= 1'b0;
      ref_clk_1_oe_out  <= 1'b0;
    end else begin
      strap_pins_out[`STRAP_SEL0]  <= usb_on;
      strap_pins_out[`STRAP_SEL1]  <= bus_on;
      strap_pins_out[`STRAP_SEL2]  <= bus_on;
      strap_pins_out[`STRAP_MODE]  <= sio_on;
      strap_pins_out[`STRAP_SWING] <= ref_on;
      strap_pins_oe_out <= {5{latched_reg}};
      bus_clk_5_out     <= bus_on;
      bus_clk_5_oe_out  <= latched_reg && pin_mode;
      ref_clk_1_out     <= ref_on;
      ref_clk_1_oe_out  <= latched_reg && pin_mode;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      proc_swing_sel_out <= 1'b0;
      freq_sel_out       <= 3'h0;
    end else begin
      proc_swing_sel_out <= strap_reg[`STRAP_SWING];
      freq_sel_out       <= freq_sel;
    end
  end

  // ==========================================================
  // Checks
  logic [31:0] wake_cnt_reg;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      wake_cnt_reg <= 32'h0000_0000;
    end else if (standby_act || !latched_reg || nco_clk[`NCO_PROC]) begin
      wake_cnt_reg <= 32'h0000_0000;
    end else begin
      wake_cnt_reg <= wake_cnt_reg + 32'h0000_0001;
    end
  end

  a_oe_before_latch: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !latched_reg |=> (strap_pins_oe_out == 5'h00 && !bus_clk_5_oe_out && !ref_clk_1_oe_out))
    else $error("pin driven before straps were latched");
  a_sample_length: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (state_reg == clock_ctrl_pkg::ST_SAMPLE && timer_reg != 32'(SAMPLE_CYCLES - 1)) |=> !latched_reg)
    else $error("straps latched before sampling window ended");
  a_strap_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    latched_reg |=> (latched_reg && $stable(strap_reg)))
    else $error("latched strap changed after power-up");
  a_strap_capture: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $rose(latched_reg) |-> strap_reg == $past(filt_reg[4:0]))
    else $error("strap value differs from pin level");
  a_standby_low: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    standby_act [*8] |-> (proc_clk_out == 4'h0 && mem_clk_out == 12'h000 && bus_clk_out == 4'h0
                          && !irq_ctrl_clk_out && strap_pins_out == 5'h00 && !ref_clk_1_out))
    else $error("clock output high during standby");
  a_halt_stop: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    halt_act [*8] |-> proc_clk_out == 4'h0)
    else $error("processor clock still running under halt");
  a_mem_proc_sync: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (proc_clk_out[0] && !$past(ctrl_reg[`CTRL_DIS_MEM])) |-> mem_clk_out == 12'hfff)
    else $error("memory clocks out of step with processor clocks");
  a_pin_roles: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    latched_reg |=> (bus_clk_5_oe_out == pin_mode && ref_clk_1_oe_out == pin_mode))
    else $error("pin role does not follow latched mode strap");
  a_swing_sel: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    latched_reg [*2] |-> proc_swing_sel_out == strap_reg[`STRAP_SWING])
    else $error("buffer swing select not from latched strap");
  a_freq_kept: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $fell(standby_act) |-> (proc_inc == $past(proc_inc) && bus_inc == $past(bus_inc)))
    else $error("frequency changed across standby");
  a_restart_bound: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    wake_cnt_reg < 32'(`RESTART_CYCLES))
    else $error("clock did not restart after standby");

  c_latch_done: cover property (@(posedge mclk_in) disable iff (!rst_n_in) $rose(latched_reg));
  c_standby_exit: cover property (@(posedge mclk_in) disable iff (!rst_n_in) $fell(standby_act));
  c_halt_release: cover property (@(posedge mclk_in) disable iff (!rst_n_in) $fell(halt_act));
  c_mode_outputs: cover property (@(posedge mclk_in) disable iff (!rst_n_in) bus_clk_5_oe_out);

endmodule

// *** verification/strap_partner.sv ***
// Far-side model: strap resistors on the dual-purpose pins and chipset standby/halt lines
// Assumes the bench sets pull levels and control levels; wires resolve from the enables
`timescale 1ns/100ps
module strap_partner (
  input  wire logic [4:0] pull_in,
  input  wire logic       standby_n_in,
  input  wire logic       halt_n_in,
  input  wire logic [4:0] pins_in,
  input  wire logic [4:0] pins_oe_in,
  input  wire logic       b5_in,
  input  wire logic       b5_oe_in,
  input  wire logic       r1_in,
  input  wire logic       r1_oe_in,
  output logic      [4:0] pins_out,
  output logic            b5_out,
  output logic            r1_out
);
  // ==========================================================
  // Pin resolution
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pins_out[i] = pins_oe_in[i] ? pins_in[i] : pull_in[i];
    end
    b5_out = b5_oe_in ? b5_in : standby_n_in;
    r1_out = r1_oe_in ? r1_in : halt_n_in;
  end
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench of the strap latch and clock gating block
// Assumes a shortened sampling window and the partner model on the pins
`timescale 1ns/100ps
module tb_top;
  localparam int SAMP = 64;
  logic        mclk_in      = 1'b0;
  logic        rst_n_in     = 1'b0;
  logic        supply_ok_in = 1'b0;
  logic [4:0]  pull         = 5'h00;
  logic        sb_n         = 1'b1;
  logic        hl_n         = 1'b1;
  logic [3:0]  reg_addr_in  = 4'h0;
  logic [7:0]  reg_wdata_in = 8'h00;
  logic        reg_wr_in    = 1'b0;
  logic        reg_rd_in    = 1'b0;
  logic [4:0]  pins_w, pins_o, pins_oe;
  logic        b5_w, b5_o, b5_oe, r1_w, r1_o, r1_oe, irq, swing;
  logic [3:0]  proc, bus;
  logic [11:0] mem;
  logic [2:0]  fsel;
  logic [7:0]  rdata;
  logic [5:0]  probe;
  int          num_errors  = 0;
  int          comparisons = 0;

  assign probe = {r1_o, proc[0], pins_o[3], pins_o[0], irq, bus[0]};
  always #4 mclk_in = ~mclk_in;

  // ==========================================================
  // Design and partner
  clock_ctrl #(.SAMPLE_CYCLES(SAMP)) u_dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .supply_ok_in(supply_ok_in),
    .strap_pins_in(pins_w), .strap_pins_out(pins_o), .strap_pins_oe_out(pins_oe),
    .bus_clk_5_in(b5_w), .bus_clk_5_out(b5_o), .bus_clk_5_oe_out(b5_oe),
    .ref_clk_1_in(r1_w), .ref_clk_1_out(r1_o), .ref_clk_1_oe_out(r1_oe),
    .proc_clk_out(proc), .mem_clk_out(mem), .bus_clk_out(bus), .irq_ctrl_clk_out(irq),
    .proc_swing_sel_out(swing), .freq_sel_out(fsel), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(rdata));
  strap_partner u_far (
    .pull_in(pull), .standby_n_in(sb_n), .halt_n_in(hl_n), .pins_in(pins_o),
    .pins_oe_in(pins_oe), .b5_in(b5_o), .b5_oe_in(b5_oe), .r1_in(r1_o),
    .r1_oe_in(r1_oe), .pins_out(pins_w), .b5_out(b5_w), .r1_out(r1_w));

  // ==========================================================
  // Tasks
  task automatic tally_and_finish;
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic bad(input string m);
    num_errors++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic chk(input logic [25:0] g, input logic [25:0] e, input string m);
    comparisons++;
    if (g !== e) bad(m);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic rate(input int idx, input int e100);
    int   cnt;
    logic prev;
    cnt = 0;
    prev = probe[idx];
    repeat (1250) begin
      cyc(1);
      if (probe[idx] === 1'b1 && prev === 1'b0) cnt++;
      prev = probe[idx];
    end
    comparisons++;
    if (cnt * 10 > e100 + 20 || cnt * 10 < e100 - 20) bad("clock rate");
  endtask
  task automatic quiet(input int n, output logic [25:0] acc);
    acc = 26'h0;
    repeat (n) begin
      cyc(1);
      acc = acc | {proc, mem, bus, irq, pins_o};
    end
  endtask
  task automatic set_ctl(input logic s, input logic h);
    @(posedge mclk_in);
    sb_n <= s;
    hl_n <= h;
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [7:0] w);
    @(posedge mclk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= w;
    reg_wr_in    <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic powerup(input logic [4:0] s);
    int n;
    @(posedge mclk_in);
    rst_n_in     <= 1'b0;
    supply_ok_in <= 1'b0;
    pull         <= s;
    repeat (8) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    supply_ok_in <= 1'b1;
    for (n = 0; n < 200 && pins_oe !== 5'h1f; n++) cyc(1);
    if (n == 200) begin
      bad("no strap latch");
      tally_and_finish();
    end
    chk(n >= SAMP && n <= SAMP + 8, 1, "strap window");
  endtask

  // ==========================================================
  // Rows: strap levels {swing, mode, sel} and bus clock in 10 kHz units
  logic [4:0] row_strap [8] = '{5'h10, 5'h09, 5'h02, 5'h1b, 5'h04, 5'h0d, 5'h16, 5'h07};
  int         row_bus   [8] = '{2500, 3200, 4165, 3425, 2750, 3750, 3000, 3340};

  initial begin
    logic [4:0]  s;
    logic [7:0]  d;
    logic [25:0] acc;
    for (int r = 0; r < 8; r++) begin
      s = row_strap[r];
      powerup(s);
      chk(fsel, s[2:0], "freq select");
      chk(swing, s[4], "swing select");
      chk({b5_oe, r1_oe}, {2{s[3]}}, "pin role");
      if (s[3]) chk(b5_o, bus[0], "bus clk 5");
      reg_read(4'h4, d);
      chk(d, {2'b00, 1'b1, s[4], s[3], s[2:0]}, "status");
      rate(0, row_bus[r]);
      rate(1, 1432);
      rate(2, 4800);
      rate(3, 2400);
      if (s[3]) rate(5, 1432);
    end
    @(posedge mclk_in);
    pull         <= 5'h18;
    supply_ok_in <= 1'b0;
    cyc(16);
    chk(fsel, 3'h7, "straps held");
    repeat (32) begin
      cyc(1);
      chk({mem, proc}, {{12{proc[0]}}, {4{proc[0]}}}, "mem sync");
    end
    reg_write(4'h0, 8'h01);
    cyc(40);
    quiet(32, acc);
    chk(acc[25:22], 4'h0, "proc disabled");
    chk(acc[21:10] != 12'h0, 1, "mem running");
    reg_read(4'h0, d);
    chk(d, 8'h01, "ctrl readback");
    reg_write(4'h8, 8'hff);
    reg_read(4'h8, d);
    chk(d, 8'h00, "unmapped read");
    reg_read(4'h0, d);
    chk(d, 8'h01, "unmapped write");
    reg_write(4'h0, 8'h1e);
    cyc(16);
    quiet(32, acc);
    chk(acc[21:0], 22'h0, "outputs disabled");
    chk(acc[25:22] != 4'h0, 1, "proc kept");
    reg_write(4'h0, 8'h00);
    set_ctl(1'b1, 1'b0);
    cyc(40);
    quiet(32, acc);
    chk(acc[25:22], 4'h0, "halt stop");
    chk(acc[21:10] != 12'h0, 1, "mem in halt");
    reg_read(4'h4, d);
    chk(d[7], 1'b1, "halt status");
    set_ctl(1'b1, 1'b1);
    cyc(16);
    quiet(32, acc);
    chk(acc[25:22] != 4'h0, 1, "halt restart");
    set_ctl(1'b0, 1'b1);
    cyc(40);
    quiet(64, acc);
    chk(acc, 26'h0, "standby low");
    reg_read(4'h4, d);
    chk(d[6], 1'b1, "standby status");
    set_ctl(1'b1, 1'b1);
    rate(0, 3340);
    chk(fsel, 3'h7, "freq after standby");
    tally_and_finish();
  end
endmodule
